// file: arr_pkg.sv
/*
 Package for the converter result readout block: register offsets, field
 positions, reset values and timing counts.
 Assumes an 8-bit register port with byte addresses.
*/
package arr_pkg;
   // Register offsets
   localparam logic [7:0] ADDR_RES0_LOW  = 8'h60;
   localparam logic [7:0] ADDR_RES0_HIGH = 8'h61;
   localparam logic [7:0] ADDR_RES1_LOW  = 8'h62;
   localparam logic [7:0] ADDR_RES1_HIGH = 8'h63;
   localparam logic [7:0] ADDR_RES2_LOW  = 8'h64;
   localparam logic [7:0] ADDR_RES2_HIGH = 8'h65;
   localparam logic [7:0] ADDR_RES3_LOW  = 8'h66;
   localparam logic [7:0] ADDR_RES3_HIGH = 8'h67;
   localparam logic [7:0] ADDR_MODE      = 8'h68;
   localparam logic [7:0] ADDR_PORT      = 8'h69;
   localparam logic [7:0] ADDR_IRQ_STAT  = 8'h6a;
   localparam logic [7:0] ADDR_IRQ_MASK  = 8'h6b;
   localparam logic [7:0] ADDR_RES_BASE  = 8'h60;
   localparam logic [7:0] ADDR_RES_LAST  = 8'h67;
   // Mode register fields
   localparam int MODE_START_BIT = 0;
   localparam int MODE_REPEAT_BIT = 1;
   localparam int MODE_SPEED_BIT = 2;
   localparam int MODE_CH_LSB    = 4;
   localparam int MODE_BUSY_BIT  = 6;
   localparam int MODE_EOC_BIT   = 7;
   // Low byte filler bits
   localparam logic [5:0] LOW_FILL = 6'h3f;
   // Sizes
   localparam int NUM_CH   = 4;
   localparam int RES_W    = 10;
   // Successive approximation: one cycle sample, one cycle per bit
   localparam logic [3:0] SAR_STEPS = 4'ha;
   localparam logic [7:0] RESET_BYTE = 8'h00;
endpackage : arr_pkg

// file: arr_top.sv
/*
 Converter result readout: mode register, successive-approximation sequencer,
 four per-channel split result registers, shared input port and interrupt.
 Results live in one packed word, ten bits per channel; the byte registers
 are fixed views of it, so a high and a low read need no latching.
 Assumes the analog front end gives one comparator decision per clock for the
 trial value on o_sar_trial, and that software keeps the standby guidance.
 Assumes a single clock domain and a bus master that never waits.
*/
`timescale 1ns/1ns

// Summary of operation
// RULE1 - Four channels, ten bit successive approximation result
// RULE2 - Analog pins readable as digital input port
// RULE3 - Low byte holds result bits one, zero
// RULE4 - High byte holds result bits nine..two
// RULE5 - Low byte bits five..zero read one
// RULE6 - Software stops conversion before halt instruction
// RULE7 - Input sampled directly, no sample hold
// RULE8 - Start bit begins conversion; restart aborts
// RULE9 - Result stored per channel each end
// RULE10 - High byte read clears end flags
// RULE11 - Result registers read only, writes ignored
module arr_top (
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   // Register port
   input  wire logic [7:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic      [7:0] o_rdata,
   // Analog front end
   input  wire logic [3:0] i_pin_level,
   input  wire logic       i_cmp_above,
   output logic      [1:0] o_sel_ch,
   output logic      [9:0] o_sar_trial,
   output logic            o_cmp_en,
   // Interrupt
   output logic            o_irq
);

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b001,
      ST_SAMPLE = 3'b010,
      ST_CONV   = 3'b100
   } arr_state_e;

   typedef struct packed {
      arr_state_e  state;
      logic [3:0]  step;
      logic [9:0]  trial;
      logic [9:0]  sar_bit;
      logic [1:0]  ch;
      logic        repeat_en;
      logic        speed;
      logic        busy;
      logic        eoc;
      logic [39:0] results;
      logic        irq_stat;
      logic        irq_mask;
      logic [7:0]  rdata;
      logic        irq;
   } arr_state_s;

   // Whole block state and its next value
   arr_state_s s_q;
   arr_state_s s_d;
   // Decodes shared by the logic and the checks
   logic [7:0] rd_mux;
   logic       start_wr;
   logic       high_rd;
   logic       done;

   // Per channel byte views, built once in a loop
   logic [7:0] low_byte  [arr_pkg::NUM_CH];
   logic [7:0] high_byte [arr_pkg::NUM_CH];
   genvar gi;
   generate
      for (gi = 0; gi < arr_pkg::NUM_CH; gi++) begin : g_ch
         assign low_byte[gi]  = {s_q.results[gi*10 +: 2], arr_pkg::LOW_FILL}; // RULE3 RULE5
         assign high_byte[gi] = s_q.results[gi*10 + 2 +: 8]; // RULE4
      end
   endgenerate

   // Decode of the strobes that have side effects
   assign start_wr = i_wr && (i_addr == arr_pkg::ADDR_MODE) && i_wdata[arr_pkg::MODE_START_BIT];
   assign high_rd  = i_rd && (i_addr >= arr_pkg::ADDR_RES_BASE) && (i_addr <= arr_pkg::ADDR_RES_LAST)
                     && i_addr[0];
   assign done     = (s_q.state == ST_CONV) && (s_q.step == 4'h1);

   // Read multiplexer; unmapped addresses read zero
   always_comb begin
      rd_mux = arr_pkg::RESET_BYTE;
      if (i_addr == arr_pkg::ADDR_RES0_LOW) begin
         rd_mux = low_byte[0];
      end else if (i_addr == arr_pkg::ADDR_RES0_HIGH) begin
         rd_mux = high_byte[0];
      end else if (i_addr == arr_pkg::ADDR_RES1_LOW) begin
         rd_mux = low_byte[1];
      end else if (i_addr == arr_pkg::ADDR_RES1_HIGH) begin
         rd_mux = high_byte[1];
      end else if (i_addr == arr_pkg::ADDR_RES2_LOW) begin
         rd_mux = low_byte[2];
      end else if (i_addr == arr_pkg::ADDR_RES2_HIGH) begin
         rd_mux = high_byte[2];
      end else if (i_addr == arr_pkg::ADDR_RES3_LOW) begin
         rd_mux = low_byte[3];
      end else if (i_addr == arr_pkg::ADDR_RES3_HIGH) begin
         rd_mux = high_byte[3];
      end else if (i_addr == arr_pkg::ADDR_MODE) begin
         rd_mux = {s_q.eoc, s_q.busy, s_q.ch, 1'b0, s_q.speed, s_q.repeat_en, 1'b0};
      end else if (i_addr == arr_pkg::ADDR_PORT) begin
         rd_mux = {4'h0, i_pin_level}; // RULE2
      end else if (i_addr == arr_pkg::ADDR_IRQ_STAT) begin
         rd_mux = {7'h00, s_q.irq_stat};
      end else if (i_addr == arr_pkg::ADDR_IRQ_MASK) begin
         rd_mux = {7'h00, s_q.irq_mask};
      end
   end

   // Next state of the whole block
   always_comb begin
      s_d = s_q;
      s_d.rdata = i_rd ? rd_mux : arr_pkg::RESET_BYTE;
      // Mode writes; result addresses have no write path at all
      if (i_wr && i_addr == arr_pkg::ADDR_MODE) begin // RULE11
         s_d.repeat_en = i_wdata[arr_pkg::MODE_REPEAT_BIT];
         s_d.speed     = i_wdata[arr_pkg::MODE_SPEED_BIT];
         s_d.ch        = i_wdata[arr_pkg::MODE_CH_LSB +: 2];
      end
      if (i_wr && i_addr == arr_pkg::ADDR_IRQ_MASK) begin
         s_d.irq_mask = i_wdata[0];
      end
      // Clears first so that a same-cycle end of conversion wins
      if (i_wr && i_addr == arr_pkg::ADDR_IRQ_STAT && i_wdata[0]) begin
         s_d.irq_stat = 1'b0;
      end
      if (high_rd) begin
         s_d.irq_stat = 1'b0; // RULE10
         s_d.eoc      = 1'b0; // RULE10
      end
      case (s_q.state)
         ST_IDLE: begin
            // Nothing moves until a start write
         end
         ST_SAMPLE: begin
            // Pin is compared live; no hold stage exists here
            s_d.state   = ST_CONV; // RULE7
            s_d.step    = arr_pkg::SAR_STEPS;
            s_d.sar_bit = 10'h200;
            s_d.trial   = 10'h200;
         end
         ST_CONV: begin
            // One bit decided per clock, MSB first
            if (!i_cmp_above) begin // RULE1
               s_d.trial = s_q.trial & ~s_q.sar_bit;
            end
            if (s_q.step != 4'h1) begin
               s_d.trial   = (i_cmp_above ? s_q.trial : (s_q.trial & ~s_q.sar_bit)) | (s_q.sar_bit >> 1);
               s_d.sar_bit = s_q.sar_bit >> 1;
               s_d.step    = s_q.step - 4'h1;
            end else begin
               s_d.results[s_q.ch*10 +: 10] = i_cmp_above ? s_q.trial : (s_q.trial & ~s_q.sar_bit); // RULE9
               s_d.eoc      = 1'b1;
               s_d.irq_stat = 1'b1;
               s_d.step     = 4'h0;
               s_d.state    = s_q.repeat_en ? ST_SAMPLE : ST_IDLE; // RULE9
               s_d.busy     = s_q.repeat_en;
            end
         end
         default: begin
            s_d.state = ST_IDLE;
         end
      endcase
      // A start always restarts, even mid conversion
      if (start_wr) begin // RULE8
         s_d.state = ST_SAMPLE;
         s_d.busy  = 1'b1;
         s_d.step  = 4'h0;
      end
      // Registered level, so the pin never glitches
      s_d.irq = (s_d.irq_stat & s_d.irq_mask);
   end

   // State register
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s_q <= '{state: ST_IDLE, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from flip-flops
   assign o_rdata     = s_q.rdata;
   assign o_sel_ch    = s_q.ch;
   assign o_sar_trial = s_q.trial;
   assign o_cmp_en    = s_q.busy; // RULE6
   assign o_irq       = s_q.irq;

   // Checks
   // Steps of a conversion that the timing checks are built from
   sequence start_taken_seq;
      start_wr;
   endsequence

   // Sample cycle left alone by software
   sequence sample_step_seq;
      s_q.state == ST_SAMPLE && !start_wr;
   endsequence

   // Ten cycles without a restart: sample plus nine decisions
   sequence ten_quiet_seq;
      (!start_wr) [*8] ##1 (!start_wr) [*2];
   endsequence

   // Final decision that no new start overrides
   sequence last_step_seq;
      done && !start_wr;
   endsequence

   // Write strobe aimed at a result byte
   sequence result_write_seq;
      i_wr && !i_rd && !done && (i_addr >= arr_pkg::ADDR_RES_BASE) && (i_addr <= arr_pkg::ADDR_RES_LAST);
   endsequence

   // Start raises busy at once, even mid conversion
   start_busy_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE8
      start_taken_seq |=> s_q.busy && s_q.state == ST_SAMPLE)
      else $error("start did not set busy");

   // Sample lasts one cycle, then ten decisions are loaded
   conv_len_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE1
      sample_step_seq |=> s_q.state == ST_CONV && s_q.step == 4'ha)
      else $error("conversion length wrong");

   // A clean start ends exactly eleven edges later
   conv_time_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE1
      start_taken_seq ##1 ten_quiet_seq |=> done)
      else $error("conversion did not end on time");

   // End of conversion raises both flags; set wins over clears
   eoc_set_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE9
      last_step_seq |=> s_q.eoc && s_q.irq_stat)
      else $error("end flag missing");

   // Single mode drops busy and rests after storing
   busy_end_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE9
      last_step_seq ##0 !s_q.repeat_en |=> !s_q.busy && s_q.state == ST_IDLE)
      else $error("busy left high after single conversion");

   // Repeat mode goes straight back to sampling
   repeat_again_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE9
      last_step_seq ##0 s_q.repeat_en |=> s_q.busy && s_q.state == ST_SAMPLE)
      else $error("repeat mode did not restart");

   // Results move only when a conversion ends
   result_hold_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE9
      !done |=> $stable(s_q.results))
      else $error("result changed outside conversion end");

   // Comparator stays enabled for every decision
   conv_busy_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE8
      s_q.state == ST_CONV |-> o_cmp_en)
      else $error("comparator off during conversion");

   // Restart throws away the half done result
   restart_abort_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE8
      start_taken_seq ##0 (s_q.state == ST_CONV && !done) |=> s_q.state == ST_SAMPLE && $stable(s_q.results))
      else $error("restart did not abort");

   // Only a start write leaves the idle state
   idle_hold_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE8
      (s_q.state == ST_IDLE && !start_wr) |=> s_q.state == ST_IDLE)
      else $error("conversion began without start");

   // Busy bit of the mode register follows the flag
   busy_read_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE8
      (i_rd && i_addr == arr_pkg::ADDR_MODE) |=> o_rdata[arr_pkg::MODE_BUSY_BIT] == $past(s_q.busy))
      else $error("busy bit read wrong");

   // High byte read clears both flags
   high_clr_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE10
      (high_rd && !done) |=> !s_q.eoc && !s_q.irq_stat)
      else $error("high read did not clear");

   // Interrupt line drops with the cleared request
   irq_clear_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE10
      (high_rd && !done) |=> !o_irq)
      else $error("interrupt stayed after high read");

   // Interrupt line is the masked request, registered
   irq_level_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE10
      1'b1 |-> o_irq == (s_q.irq_stat && s_q.irq_mask))
      else $error("interrupt level wrong");

   // End flag holds until a high byte read
   eoc_keep_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE10
      (s_q.eoc && !high_rd) |=> s_q.eoc)
      else $error("end flag lost");

   // End flag bit of the mode register follows the flag
   eoc_read_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE10
      (i_rd && i_addr == arr_pkg::ADDR_MODE) |=> o_rdata[arr_pkg::MODE_EOC_BIT] == $past(s_q.eoc))
      else $error("end flag read wrong");

   // Filler bits of a low byte always read one
   low_fill_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE5
      (i_rd && i_addr == arr_pkg::ADDR_RES2_LOW) |=> o_rdata[5:0] == 6'h3f)
      else $error("low fill wrong");

   // High byte carries result bits nine down to two
   high_map_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE4
      (i_rd && i_addr == arr_pkg::ADDR_RES1_HIGH) |=> o_rdata == $past(s_q.results[19:12]))
      else $error("high byte map wrong");

   // Low byte carries result bits one and zero on top
   low_map_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE3
      (i_rd && i_addr == arr_pkg::ADDR_RES3_LOW) |=> o_rdata[7:6] == $past(s_q.results[31:30]))
      else $error("low byte map wrong");

   // Pins read as a digital port at any time
   port_read_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE2
      (i_rd && i_addr == arr_pkg::ADDR_PORT) |=> o_rdata[3:0] == $past(i_pin_level))
      else $error("port read wrong");

   // Bus writes never reach stored results
   ro_hold_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE11
      (i_wr && s_q.state != ST_CONV) |=> $stable(s_q.results))
      else $error("result written by bus");

   // Result address writes leave the flags alone
   ro_flags_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE11
      result_write_seq |=> $stable(s_q.eoc) && $stable(s_q.irq_stat))
      else $error("result write touched flags");

   // First trial is half scale; the pin is compared live
   sample_live_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE7
      sample_step_seq |=> o_sar_trial == 10'h200)
      else $error("trial start wrong");

endmodule : arr_top

// file: arr_afe_model.sv
/*
 Analog front end model: pin voltages and the comparator.
 Assumes channel, trial code and enable come straight from the block.
*/
`timescale 1ns/1ns
module arr_afe_model (
   // Pin voltages, ten bits per channel
   input  wire logic [39:0] i_volts,
   // From the block
   input  wire logic [1:0]  i_sel_ch,
   input  wire logic [9:0]  i_trial,
   input  wire logic        i_en,
   // To the block
   output logic             o_above
);
   logic [9:0] v;
   // No hold stage: a moving pin shows in the very next decision
   assign v = i_volts[10*i_sel_ch +: 10];
   // Disabled comparator answers nonsense, not a friendly zero
   assign o_above = i_en ? (v >= i_trial) : (v < i_trial);
endmodule : arr_afe_model

// file: tb_adc_result_readout.sv
/*
 Testbench for the result readout block, reads checked from a queue.
 Assumes the analog model above and the package offsets.
*/
`timescale 1ns/1ns
module tb_adc_result_readout;
   logic        i_clk, i_rst, i_wr, i_rd, pend, cmp, en, o_irq;
   logic [7:0]  i_addr, i_wdata, o_rdata;
   logic [3:0]  pins;
   logic [1:0]  sel;
   logic [9:0]  trial, v;
   logic [39:0] volts;
   logic [15:0] q[$];
   int          errors, n_checks, cyc;
   integer      seed;

   arr_top uut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(o_rdata), .i_pin_level(pins), .i_cmp_above(cmp), .o_sel_ch(sel),
      .o_sar_trial(trial), .o_cmp_en(en), .o_irq(o_irq));
   arr_afe_model afe (.i_volts(volts), .i_sel_ch(sel), .i_trial(trial), .i_en(en), .o_above(cmp));

   always #4 i_clk = ~i_clk;

   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      #1;
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask : chk

   // One strobe per cycle; a read leaves its mask and value in the queue
   task automatic bus(input logic w, input logic [7:0] a, d, m, e);
      i_wr <= w;
      i_rd <= ~w;
      i_addr <= a;
      i_wdata <= d;
      if (!w) q.push_back({m, e});
      @(posedge i_clk);
   endtask : bus

   task automatic idle(input int n);
      i_wr <= 1'b0;
      i_rd <= 1'b0;
      repeat (n) @(posedge i_clk);
   endtask : idle

   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : conclude

   // Read data stand only in the cycle after the strobe
   always @(posedge i_clk) pend <= i_rd;
   always @(negedge i_clk) begin
      if (pend === 1'b1) begin
         chk({2'b00, o_rdata & q[0][15:8]}, {2'b00, q[0][7:0]});
         void'(q.pop_front());
      end
   end

   // Hang guard, well above the planned run
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 6000) begin
         errors++;
         conclude();
      end
   end

   initial begin
      i_clk = 0;
      i_rst = 1;
      i_wr = 0;
      i_rd = 0;
      i_addr = 0;
      i_wdata = 0;
      volts = 0;
      seed = 32'hb9340173;
      pins = 4'($random(seed));
      repeat (12) @(posedge i_clk);
      i_rst <= 1'b0;
      bus(0, arr_pkg::ADDR_PORT, 0, 8'h0f, {4'h0, pins});
      bus(1, arr_pkg::ADDR_IRQ_MASK, 8'h01, 0, 0);
      for (int c = 0; c < 4; c++) begin
         v = 10'($random(seed));
         volts[10*c +: 10] <= v;
         bus(1, arr_pkg::ADDR_MODE, {2'b00, 2'(c), 4'h1}, 0, 0);
         idle(1);
         chk({8'h00, sel}, 10'(c));
         chk(trial, 10'h200);
         bus(0, arr_pkg::ADDR_MODE, 0, 8'h40, 8'h40);
         idle(12);
         chk({9'h0, o_irq}, 10'h001);
         bus(0, 8'(2*c) + 8'h60, 0, 8'hff, {v[1:0], 6'h3f});
         bus(0, 8'(2*c) + 8'h61, 0, 8'hff, v[9:2]);
         bus(0, arr_pkg::ADDR_MODE, 0, 8'h80, 8'h00);
         idle(2);
         chk({9'h0, o_irq}, 10'h000);
      end
      // Masked source, restart mid conversion, then clear by one
      bus(1, arr_pkg::ADDR_IRQ_MASK, 8'h00, 0, 0);
      bus(1, arr_pkg::ADDR_MODE, 8'h01, 0, 0);
      idle(5);
      bus(1, arr_pkg::ADDR_MODE, 8'h01, 0, 0);
      idle(9);
      bus(0, arr_pkg::ADDR_IRQ_STAT, 0, 8'h01, 8'h00);
      idle(4);
      bus(0, arr_pkg::ADDR_IRQ_STAT, 0, 8'h01, 8'h01);
      chk({9'h0, o_irq}, 10'h000);
      bus(1, arr_pkg::ADDR_IRQ_STAT, 8'h01, 0, 0);
      bus(0, arr_pkg::ADDR_IRQ_STAT, 0, 8'h01, 8'h00);
      // Result bytes are read only; unmapped reads give zero
      bus(1, arr_pkg::ADDR_RES3_HIGH, ~v[9:2], 0, 0);
      bus(0, arr_pkg::ADDR_MODE, 0, 8'h80, 8'h80);
      bus(0, arr_pkg::ADDR_RES3_HIGH, 0, 8'hff, v[9:2]);
      bus(0, 8'h70, 0, 8'hff, 8'h00);
      // Repeat mode keeps refreshing channel zero
      bus(1, arr_pkg::ADDR_MODE, 8'h03, 0, 0);
      idle(13);
      chk({9'h0, en}, 10'h001);
      v = 10'($random(seed));
      volts[9:0] <= v;
      idle(27);
      bus(0, arr_pkg::ADDR_RES0_HIGH, 0, 8'hff, v[9:2]);
      bus(0, arr_pkg::ADDR_RES0_LOW, 0, 8'hff, {v[1:0], 6'h3f});
      // Stop and leave the speed bit at zero before any halt
      bus(1, arr_pkg::ADDR_MODE, 8'h00, 0, 0);
      idle(14);
      chk({9'h0, en}, 10'h000);
      conclude();
   end
endmodule : tb_adc_result_readout
